// ---- hw/sarpf_ctrl.sv ----
// successive-approximation converter control with threshold compare, APB slave
//
// Design decision made here: the APB register port.
module sarpf_ctrl (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [17:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    // analog front end
    input  wire logic        comp_hi_i,     // comparator: input at or above tap (async)
    output logic [2:0]       chan_sel_o,    // analog input multiplexer select
    output logic             sample_o,      // sample-and-hold tracking when high
    output logic [7:0]       tap_code_o,    // resistor-string tap code
    // event
    output logic             conv_done_irq_o // one-cycle conversion-end request
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_reg, mode_next;       // conv_mode_ctrl
    logic [7:0] chan_reg, chan_next;       // input_channel_select
    logic [7:0] cmpm_reg, cmpm_next;       // threshold_compare_mode
    logic [7:0] thr_reg,  thr_next;        // threshold_value
    logic [7:0] res_reg,  res_next;        // conv_result
    logic [7:0] sar_reg,  sar_next;        // approx_reg
    logic [7:0] bit_reg,  bit_next;        // one-hot bit under trial
    logic       first_reg, first_next;     // first conversion since run set
    logic       irq_reg,  irq_next;        // interrupt pulse
    logic [31:0] rd_reg,  rd_next;         // read data flop
    sarpf_pkg::sarpf_state_type st_reg, st_next;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        acc;          // access phase; always ready in one cycle
    logic        wr;           // write taken this edge
    logic        rd;           // read data latched in the setup cycle
    logic [15:0] idx;          // register index from byte address
    logic        hit;          // address maps to a register
    logic        wr_mode, wr_chan, wr_ctl;
    logic        lane0;        // low byte lane enabled

    assign acc     = psel_i && penable_i;
    assign idx     = paddr_i[17:2];
    assign hit     = (idx >= sarpf_pkg::IDX_MODE) && (idx <= sarpf_pkg::IDX_STATUS)
                     && (paddr_i[1:0] == 2'h0);
    assign wr      = acc && pwrite_i && hit;
    // latching in setup keeps prdata_o a flop yet valid through the access phase
    assign rd      = psel_i && !penable_i && !pwrite_i && hit;
    assign lane0   = pstrb_i[0];
    assign wr_mode = wr && lane0 && (idx == sarpf_pkg::IDX_MODE);
    assign wr_chan = wr && lane0 && (idx == sarpf_pkg::IDX_CHAN);
    assign wr_ctl  = wr_mode || wr_chan;

    // zero wait states; unmapped or result/status writes flag an error
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && (!hit || (pwrite_i && ((idx == sarpf_pkg::IDX_RESULT)
                       || (idx == sarpf_pkg::IDX_STATUS))));
    assign prdata_o  = rd_reg;

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    logic cmp_s1_reg, cmp_s2_reg;   // second stage alone feeds logic

    // two flops against the asynchronous comparator output
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cmp_s1_reg <= 1'b0;
            cmp_s2_reg <= 1'b0;
        end else begin
            cmp_s1_reg <= comp_hi_i;
            cmp_s2_reg <= cmp_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // step timing
    // ------------------------------------------------------------
    logic run;        // conv_run
    logic restart;    // timer reload
    logic tick;       // step end
    logic [3:0] samp_reg, samp_next;   // sampling step count

    assign run     = mode_reg[sarpf_pkg::MODE_RUN_BIT];
    assign restart = wr_ctl || !run || (st_reg == sarpf_pkg::SARPF_IDLE);

    sarpf_step_timer u_timer (
        .sys_clk_i  (sys_clk_i),
        .reset_i    (reset_i),
        .restart_i  (restart),
        .time_sel_i (mode_reg[sarpf_pkg::MODE_TS_HI:sarpf_pkg::MODE_TS_LO]),
        .tick_o     (tick)
    );

    // ------------------------------------------------------------
    // sequencer and result
    // ------------------------------------------------------------
    logic cmp_hold;   // selected relation holds for the new code
    logic [7:0] code; // code once last bit resolved

    // last bit kept or cleared on the final comparator decision
    assign code = cmp_s2_reg ? sar_reg : (sar_reg & ~bit_reg);
    // threshold read live, so a write counts from the next compare
    assign cmp_hold = cmpm_reg[sarpf_pkg::CMP_DIR_BIT] ? (code < thr_reg)
                                                         : (code >= thr_reg);

    // next values of the conversion state
    always_comb begin
        st_next    = st_reg;
        sar_next   = sar_reg;
        bit_next   = bit_reg;
        samp_next  = samp_reg;
        first_next = first_reg;
        res_next   = res_reg;
        irq_next   = 1'b0;
        if (wr_ctl || !run) begin
            // abort; a run restart begins from sampling
            st_next   = run ? sarpf_pkg::SARPF_SAMPLE : sarpf_pkg::SARPF_IDLE;
            samp_next = 4'h0;
            if (wr_mode && pwdata_i[sarpf_pkg::MODE_RUN_BIT] && !run) begin
                first_next = 1'b1;
            end
            if (wr_ctl) begin
                st_next = sarpf_pkg::SARPF_IDLE;                     // reload next
            end
        end else begin
            case (st_reg)
                sarpf_pkg::SARPF_IDLE: begin
                    st_next   = sarpf_pkg::SARPF_SAMPLE;
                    samp_next = 4'h0;
                end
                sarpf_pkg::SARPF_SAMPLE: begin
                    if (tick) begin
                        samp_next = samp_reg + 4'h1;
                        if (samp_reg == sarpf_pkg::SAMPLE_SHARE - 4'h1) begin
                            st_next  = sarpf_pkg::SARPF_STEP;
                            sar_next = sarpf_pkg::SAR_MSB;
                            bit_next = sarpf_pkg::SAR_MSB;
                        end
                    end
                end
                sarpf_pkg::SARPF_STEP: begin
                    if (tick) begin
                        if (bit_reg[0]) begin
                            // result loaded; read took old value
                            res_next   = code;
                            irq_next   = !cmpm_reg[sarpf_pkg::CMP_EN_BIT]
                                         || (cmp_hold && !first_reg);
                            first_next = 1'b0;
                            st_next    = sarpf_pkg::SARPF_SAMPLE;
                            samp_next  = 4'h0;
                        end else begin
                            // one decision per step, then trial of next bit
                            sar_next = code | (bit_reg >> 1);
                            bit_next = bit_reg >> 1;
                        end
                    end
                end
                default: st_next = sarpf_pkg::SARPF_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // register file next values
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        chan_next = chan_reg;
        cmpm_next = cmpm_reg;
        thr_next  = thr_reg;
        rd_next   = rd_reg;
        if (wr && lane0) begin
            case (idx)
                sarpf_pkg::IDX_MODE:    mode_next = pwdata_i[7:0];
                sarpf_pkg::IDX_CHAN:    chan_next = pwdata_i[7:0];
                sarpf_pkg::IDX_CMPMODE: cmpm_next = pwdata_i[7:0];
                sarpf_pkg::IDX_THRESH:  thr_next  = pwdata_i[7:0];
                default:                thr_next  = thr_reg;  // result is read-only
            endcase
        end
        if (rd) begin
            // sampled from the old result, so a coincident update follows it
            case (idx)
                sarpf_pkg::IDX_MODE:    rd_next = {24'h000000, mode_reg};
                sarpf_pkg::IDX_CHAN:    rd_next = {24'h000000, chan_reg};
                sarpf_pkg::IDX_CMPMODE: rd_next = {24'h000000, cmpm_reg};
                sarpf_pkg::IDX_THRESH:  rd_next = {24'h000000, thr_reg};
                sarpf_pkg::IDX_RESULT:  rd_next = {24'h000000, res_reg};
                sarpf_pkg::IDX_STATUS:  rd_next = {22'h0, st_reg, sar_reg};
                default:                rd_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_reg  <= sarpf_pkg::REG_RESET;
            chan_reg  <= sarpf_pkg::REG_RESET;
            cmpm_reg  <= sarpf_pkg::REG_RESET;
            thr_reg   <= sarpf_pkg::REG_RESET;
            res_reg   <= sarpf_pkg::REG_RESET;
            sar_reg   <= sarpf_pkg::REG_RESET;
            bit_reg   <= sarpf_pkg::REG_RESET;
            first_reg <= 1'b0;
            irq_reg   <= 1'b0;
            samp_reg  <= 4'h0;
            rd_reg    <= 32'h00000000;
            st_reg    <= sarpf_pkg::SARPF_IDLE;
        end else begin
            mode_reg  <= mode_next;
            chan_reg  <= chan_next;
            cmpm_reg  <= cmpm_next;
            thr_reg   <= thr_next;
            res_reg   <= res_next;
            sar_reg   <= sar_next;
            bit_reg   <= bit_next;
            first_reg <= first_next;
            irq_reg   <= irq_next;
            samp_reg  <= samp_next;
            rd_reg    <= rd_next;
            st_reg    <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs to the analog side and the interrupt request
    // ------------------------------------------------------------
    // prohibited channel codes are clamped to the top input
    assign chan_sel_o = (chan_reg[sarpf_pkg::CHAN_HI:0] > sarpf_pkg::CHAN_MAX)
                        ? sarpf_pkg::CHAN_MAX : chan_reg[sarpf_pkg::CHAN_HI:0];
    assign sample_o        = (st_reg == sarpf_pkg::SARPF_SAMPLE);
    assign tap_code_o      = sar_reg;
    assign conv_done_irq_o = irq_reg;

endmodule // sarpf_ctrl

// ---- hw/sarpf_step_timer.sv ----
// step timer: turns a conversion-time code into a per-step tick
module sarpf_step_timer (
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    // control
    input  wire logic       restart_i,    // reload the count from zero
    input  wire logic [2:0] time_sel_i,   // conversion-time code
    // tick out
    output logic            tick_o        // one-cycle pulse at end of each step
);

    // ------------------------------------------------------------
    // step length from the period code
    // ------------------------------------------------------------
    logic [8:0] period;      // whole conversion length in cycles
    logic [5:0] step_len;    // one twelfth of the period
    logic [5:0] cnt_reg;     // cycles counted in the current step
    logic [5:0] cnt_next;

    // period lookup; prohibited codes fall back to the longest period
    always_comb begin
        case (time_sel_i)
            3'h0:    period = sarpf_pkg::CONV_144;
            3'h1:    period = sarpf_pkg::CONV_120;
            3'h2:    period = sarpf_pkg::CONV_96;
            3'h4:    period = sarpf_pkg::CONV_288;
            3'h5:    period = sarpf_pkg::CONV_240;
            3'h6:    period = sarpf_pkg::CONV_192;
            default: period = sarpf_pkg::CONV_288;
        endcase
    end

    // every legal period divides evenly by twelve, so sample + 8 steps sum exactly
    assign step_len = 6'(period / 9'(sarpf_pkg::PERIOD_DIV));

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // next count: wraps at the step length
    always_comb begin
        if (restart_i || tick_o) begin
            cnt_next = 6'h00;
        end else begin
            cnt_next = cnt_reg + 6'h01;
        end
    end

    // register the count
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick_o = !restart_i && (cnt_reg == step_len - 6'h01);

endmodule // sarpf_step_timer

// ---- pkg/sarpf_pkg.sv ----
// package with register map, field layout and timing constants of the converter control
package sarpf_pkg;

    // ------------------------------------------------------------
    // register word indices, byte address bits 17:2 (printed offsets are not multiples of four)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_MODE      = 16'hFF80;  // conv_mode_ctrl index
    localparam logic [15:0] IDX_CHAN      = 16'hFF81;  // input_channel_select index
    localparam logic [15:0] IDX_CMPMODE   = 16'hFF82;  // threshold_compare_mode index
    localparam logic [15:0] IDX_THRESH    = 16'hFF83;  // threshold_value index
    localparam logic [15:0] IDX_RESULT    = 16'hFF84;  // conv_result index
    localparam logic [15:0] IDX_STATUS    = 16'hFF85;  // status index
    localparam int          ADDR_W        = 18;        // byte address width

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          MODE_RUN_BIT  = 7;         // conv_run
    localparam int          MODE_TS_HI    = 5;         // conv_time_sel_2
    localparam int          MODE_TS_LO    = 3;         // conv_time_sel_0
    localparam int          CHAN_HI       = 2;         // chan_sel_2
    localparam int          CMP_EN_BIT    = 7;         // compare_enable
    localparam int          CMP_DIR_BIT   = 6;         // compare_direction
    localparam logic [7:0]  REG_RESET     = 8'h00;     // reset value of every register
    localparam logic [7:0]  SAR_MSB       = 8'h80;     // first trial code
    localparam logic [2:0]  CHAN_MAX      = 3'h4;      // highest legal channel code

    // ------------------------------------------------------------
    // conversion time codes, in main clock cycles
    // ------------------------------------------------------------
    localparam logic [8:0]  CONV_144      = 9'h090;
    localparam logic [8:0]  CONV_120      = 9'h078;
    localparam logic [8:0]  CONV_96       = 9'h060;
    localparam logic [8:0]  CONV_288      = 9'h120;
    localparam logic [8:0]  CONV_240      = 9'h0F0;
    localparam logic [8:0]  CONV_192      = 9'h0C0;
    localparam logic [3:0]  NUM_STEPS     = 4'h8;      // compare steps per conversion
    localparam logic [3:0]  SAMPLE_SHARE  = 4'h4;      // sampling phase = 4 step lengths
    localparam logic [3:0]  PERIOD_DIV    = 4'hC;      // period split into 12 step lengths

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SARPF_IDLE   = 2'b00,
        SARPF_SAMPLE = 2'b01,
        SARPF_STEP   = 2'b10
    } sarpf_state_type;

endpackage : sarpf_pkg

// ---- testbench/sarpf_ctrl_properties.sv ----
// port-level checker of the converter control
module sarpf_ctrl_properties (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    // register bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // front end and event
    input wire logic [2:0]  chan_sel_o,
    input wire logic        sample_o,
    input wire logic [7:0]  tap_code_o,
    input wire logic        conv_done_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // ------------------------------------------------------------
    // decoded accesses
    // ------------------------------------------------------------
    logic acc;      // access completes at this edge
    logic wr_mode;  // mode register written
    logic wr_chan;  // channel register written
    assign acc     = psel_i & penable_i & pready_o;
    assign wr_mode = acc & pwrite_i & pstrb_i[0] & (paddr_i[17:2] == sarpf_pkg::IDX_MODE);
    assign wr_chan = acc & pwrite_i & pstrb_i[0] & (paddr_i[17:2] == sarpf_pkg::IDX_CHAN);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_result_ro;
        acc && pwrite_i && paddr_i[17:2] == sarpf_pkg::IDX_RESULT |-> pslverr_o;
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result write not refused");
    property p_chan_range;
        chan_sel_o <= sarpf_pkg::CHAN_MAX;
    endproperty
    a_chan_range: assert property (p_chan_range) else $error("channel out of range");
    property p_chan_follow;
        wr_chan && pwdata_i[2:0] <= 3'h4 |=> chan_sel_o == $past(pwdata_i[2:0]);
    endproperty
    a_chan_follow: assert property (p_chan_follow) else $error("channel not applied");
    property p_irq_pulse;
        conv_done_irq_o |=> !conv_done_irq_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("request longer than a cycle");
    property p_first_trial;
        $fell(sample_o) && !$past(wr_mode || wr_chan) |-> tap_code_o == sarpf_pkg::SAR_MSB;
    endproperty
    a_first_trial: assert property (p_first_trial) else $error("first trial not msb");
    property p_quiet;
        wr_mode || wr_chan |=> (!conv_done_irq_o)[*8];
    endproperty
    a_quiet: assert property (p_quiet) else $error("request after abort");
    property p_stop;
        wr_mode && !pwdata_i[7] |-> ##2 (!sample_o && !conv_done_irq_o)[*7];
    endproperty
    a_stop: assert property (p_stop) else $error("activity after stop");
    property p_restart;
        wr_mode && pwdata_i[7] |-> ##[1:3] sample_o;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after write");
    property p_back_to_back;
        $rose(conv_done_irq_o) |-> ##[0:1] sample_o;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("no next sampling");
endmodule // sarpf_ctrl_properties

bind sarpf_ctrl sarpf_ctrl_properties u_props (.sys_clk_i, .reset_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .pslverr_o, .chan_sel_o,
    .sample_o, .tap_code_o, .conv_done_irq_o);

// ---- testbench/sarpf_front_model.sv ----
// behavioural sample-and-hold, tap string and comparator
module sarpf_front_model (
    // from the controller
    input  wire logic       sys_clk_i,
    input  wire logic [2:0] chan_sel_i,
    input  wire logic       sample_i,
    input  wire logic [7:0] tap_code_i,
    input  wire logic [8:0] level_i [5],  // inputs in half-lsb units
    // to the controller
    output logic            comp_hi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] held = 9'h000;  // held input level
    // track while sampling, hold through the compare steps
    always_ff @(posedge sys_clk_i) begin
        if (sample_i) begin
            held <= level_i[chan_sel_i];
        end
    end
    // taps sit half an lsb low so the search rounds to nearest
    assign comp_hi_o = ({1'b0, held} >= ({1'b0, tap_code_i, 1'b0} - 10'h001));
endmodule // sarpf_front_model

// ---- testbench/test_sar_adc_powerfail_control.sv ----
// self-checking bench of the converter control over its register bus
module test_sar_adc_powerfail_control;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [17:0] paddr_i   = 18'h00000;
    logic [31:0] pwdata_i  = 32'h0;
    logic [3:0]  pstrb_i   = 4'hF;
    logic        pready_o, pslverr_o, comp_hi_i, sample_o, conv_done_irq_o;
    logic [31:0] prdata_o;
    logic [2:0]  chan_sel_o;
    logic [7:0]  tap_code_o;
    logic [8:0]  level [5] = '{9'h000, 9'h001, 9'h0C9, 9'h028, 9'h1FE};
    logic [2:0]  code [6]  = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int          per [6]   = '{144, 120, 96, 288, 240, 192};
    int          n_mismatch = 0, check_count = 0, irq_n = 0, cyc = 0, last_irq = 0, gap = 0;

    sarpf_ctrl dut (.sys_clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .pstrb_i, .pready_o, .pslverr_o, .prdata_o, .comp_hi_i, .chan_sel_o,
        .sample_o, .tap_code_o, .conv_done_irq_o);
    sarpf_front_model u_front (.sys_clk_i, .chan_sel_i(chan_sel_o), .sample_i(sample_o),
        .tap_code_i(tap_code_o), .level_i(level), .comp_hi_o(comp_hi_i));

    initial forever #10 sys_clk_i = ~sys_clk_i;

    // count requests and spacing; the ceiling cuts a hang short
    always @(posedge sys_clk_i) begin
        cyc++;
        if (conv_done_irq_o === 1'b1) begin
            irq_n++;
            gap = cyc - last_irq;
            last_irq = cyc;
        end
        if (cyc == 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("mismatches %0d of %0d checks", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one bus transfer; read data and response are taken at the completing edge
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        @(posedge sys_clk_i);
        psel_i   <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i  <= {idx, 2'b00};
        pwdata_i <= {24'h000000, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        e = pslverr_o;
        r = prdata_o[7:0];
        psel_i   <= 1'b0;
        penable_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic wait_irq();
        int s;
        s = irq_n;
        while (irq_n == s) @(posedge sys_clk_i);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] r;
        logic       e;
        int         c;
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, sarpf_pkg::IDX_MODE + 16'(i), 8'h00, r, e);
            check(32'(r), 32'h0);
        end
        apb(1'b1, sarpf_pkg::IDX_RESULT, 8'hAA, r, e);
        check(32'(e), 32'h1);
        // every channel, each result rounded from its level
        for (int ch = 0; ch < 5; ch++) begin
            apb(1'b1, sarpf_pkg::IDX_CHAN, 8'(ch), r, e);
            check(32'(chan_sel_o), 32'(ch));
            if (ch == 0) apb(1'b1, sarpf_pkg::IDX_MODE, 8'hA0, r, e);
            wait_irq();
            wait_irq();
            apb(1'b0, sarpf_pkg::IDX_RESULT, 8'h00, r, e);
            check(32'(r), 32'((level[ch] + 9'h001) >> 1));
        end
        // each legal time code sets the spacing of back-to-back conversions
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, sarpf_pkg::IDX_MODE, {2'b10, code[k], 3'h0}, r, e);
            wait_irq();
            wait_irq();
            check(32'(gap), 32'(per[k]));
        end
        // threshold equal to the result: first conversion stays silent
        apb(1'b1, sarpf_pkg::IDX_MODE, 8'h10, r, e);
        apb(1'b1, sarpf_pkg::IDX_CHAN, 8'h02, r, e);
        apb(1'b1, sarpf_pkg::IDX_CMPMODE, 8'h80, r, e);
        apb(1'b1, sarpf_pkg::IDX_THRESH, 8'h65, r, e);
        apb(1'b1, sarpf_pkg::IDX_MODE, 8'h90, r, e);
        c = irq_n;
        repeat (150) @(posedge sys_clk_i);
        check(32'(irq_n - c), 32'h0);
        repeat (100) @(posedge sys_clk_i);
        check(32'(irq_n - c), 32'h1);
        // below-direction is silent at equality, fires once threshold rises
        apb(1'b1, sarpf_pkg::IDX_CMPMODE, 8'hC0, r, e);
        c = irq_n;
        repeat (300) @(posedge sys_clk_i);
        check(32'(irq_n - c), 32'h0);
        apb(1'b1, sarpf_pkg::IDX_THRESH, 8'h66, r, e);
        c = irq_n;
        repeat (200) @(posedge sys_clk_i);
        check(32'(irq_n > c), 32'h1);
        // stop halts all activity, result kept and read-only
        apb(1'b1, sarpf_pkg::IDX_MODE, 8'h10, r, e);
        c = irq_n;
        repeat (400) @(posedge sys_clk_i);
        check(32'(irq_n - c), 32'h0);
        check(32'(sample_o), 32'h0);
        apb(1'b1, sarpf_pkg::IDX_RESULT, 8'h00, r, e);
        apb(1'b0, sarpf_pkg::IDX_RESULT, 8'h00, r, e);
        check(32'(r), 32'h65);
        test_done();
    end
endmodule // test_sar_adc_powerfail_control
